/* File: rtl/cae_consts.vh */
// Constants for the add-with-carry, page jump, logical AND and compare-branch executor.
// Assumes it is included by bare name from the executor files only.
`ifndef CAE_CONSTS_VH
`define CAE_CONSTS_VH

// Opcode patterns
`define CAE_OP_ADD_WITH_CARRY_OP_REG  8'b00111???
`define CAE_OP_ADD_WITH_CARRY_OP_IND  8'b0011011?
`define CAE_OP_ADD_WITH_CARRY_OP_DIR  8'h35
`define CAE_OP_ADD_WITH_CARRY_OP_IMM  8'h34
`define CAE_OP_JUMP_PAGE 8'b???00001
`define CAE_OP_AND_REG   8'b01011???
`define CAE_OP_AND_IND   8'b0101011?
`define CAE_OP_AND_DIR   8'h55
`define CAE_OP_AND_IMM   8'h54
`define CAE_OP_AND_DA    8'h52
`define CAE_OP_AND_DI    8'h53
`define CAE_OP_AND_CB    8'h82
`define CAE_OP_AND_CNB   8'hb0
`define CAE_OP_CMP_AD    8'hb5
`define CAE_OP_CMP_AI    8'hb4
`define CAE_OP_CMP_RI    8'b10111???
`define CAE_OP_CMP_II    8'b1011011?

// Instruction kinds
`define CAE_K_NONE    4'h0
`define CAE_K_ADD_WITH_CARRY_OP    4'h1
`define CAE_K_JUMP    4'h2
`define CAE_K_AND_A   4'h3
`define CAE_K_AND_DA  4'h4
`define CAE_K_AND_DI  4'h5
`define CAE_K_AND_CB  4'h6
`define CAE_K_AND_CNB 4'h7
`define CAE_K_CMP_AD  4'h8
`define CAE_K_CMP_AI  4'h9
`define CAE_K_CMP_RI  4'ha
`define CAE_K_CMP_II  4'hb

// Operand fetch modes
`define CAE_SRC_NONE 3'h0
`define CAE_SRC_REG  3'h1
`define CAE_SRC_DIR  3'h2
`define CAE_SRC_IND  3'h3
`define CAE_SRC_BIT  3'h4

// Memory spaces on the operand port
`define CAE_SP_DIR 2'h0
`define CAE_SP_IND 2'h1
`define CAE_SP_BIT 2'h2

// Timing: reference clocks per machine cycle, machine cycles per instruction
`define CAE_MC_CLKS 4'hc
`define CAE_MC_ONE  2'h1
`define CAE_MC_TWO  2'h2

// Instruction lengths
`define CAE_LEN_JUMP 16'h0002
`define CAE_LEN_CMP  16'h0003

`endif

/* File: rtl/cae_alu.v */
// Combinational datapath: add with carry and flags, AND, unsigned compare.
// Assumes the caller registers every result it keeps.
`timescale 1ns/1ps
module cae_alu (
  input  wire [7:0] a_i,
  input  wire [7:0] b_i,
  input  wire       cin_i,
  output wire [7:0] sum_o,
  output wire       carry_o,
  output wire       aux_carry_o,
  output wire       overflow_o,
  output wire [7:0] and_o,
  output wire       less_o,
  output wire       unequal_o
);
  wire [4:0] low_sum;
  wire [7:0] mid_sum;
  wire [8:0] full_sum;

  // Separate partial sums expose the carries out of bits 3 and 6
  assign low_sum     = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
  assign mid_sum     = {1'b0, a_i[6:0]} + {1'b0, b_i[6:0]} + {7'h00, cin_i};
  assign full_sum    = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
  assign sum_o       = full_sum[7:0];
  assign carry_o     = full_sum[8];
  assign aux_carry_o = low_sum[4];
  assign overflow_o  = full_sum[8] ^ mid_sum[7];
  assign and_o       = a_i & b_i;
  assign less_o      = a_i < b_i;
  assign unequal_o   = a_i != b_i;
endmodule // cae_alu

/* File: rtl/cae_exec.v */
// Executor for add-with-carry, page jump, byte and bit AND, and compare-branch.
// Assumes fetch hands over all instruction bytes with start, and that the
// register/RAM file answers a read within the cycle in which the strobe stands.
`timescale 1ns/1ps
`include "cae_consts.vh"
module cae_exec #(
  parameter [3:0] MC_CLKS = `CAE_MC_CLKS
) (
  input  wire        ref_clk_i,
  input  wire        reset_i,
  input  wire        start_i,
  input  wire [7:0]  opcode_i,
  input  wire [7:0]  byte2_i,
  input  wire [7:0]  byte3_i,
  input  wire [15:0] program_counter_i,
  input  wire [1:0]  bank_i,
  input  wire [7:0]  acc_i,
  input  wire        carry_i,
  input  wire [7:0]  mem_rdata_i,
  output wire        busy_o,
  output reg         done_o,
  output reg         mem_rd_o,
  output reg         mem_wr_o,
  output reg         mem_rmw_o,
  output reg  [1:0]  mem_space_o,
  output reg  [7:0]  mem_addr_o,
  output reg  [7:0]  mem_wdata_o,
  output reg         acc_we_o,
  output reg  [7:0]  acc_o,
  output reg         carry_we_o,
  output reg         carry_o,
  output reg         aux_carry_we_o,
  output reg         aux_carry_flag_o,
  output reg         overflow_we_o,
  output reg         overflow_flag_o,
  output reg         program_counter_we_o,
  output reg  [15:0] program_counter_o
);
  localparam S_IDLE = 4'b0001;
  localparam S_READ = 4'b0010;
  localparam S_EXEC = 4'b0100;
  localparam S_WAIT = 4'b1000;

  reg  [3:0]  state;
  reg  [3:0]  kind;
  reg  [2:0]  src;
  reg  [7:0]  op;
  reg  [7:0]  b2;
  reg  [7:0]  b3;
  reg  [15:0] pc_base;
  reg  [7:0]  acc;
  reg         cy;
  reg         ptr_pending;
  reg  [7:0]  opnd;
  reg  [1:0]  mc_left;
  reg  [3:0]  div;
  reg  [7:0]  alu_a;
  reg  [7:0]  alu_b;
  wire        mc_tick;
  wire [7:0]  sum;
  wire        add_cy;
  wire        add_ac;
  wire        add_ov;
  wire [7:0]  and_res;
  wire        less;
  wire        unequal;
  wire [15:0] next_jump;
  wire [15:0] next_cmp;
  wire [15:0] cmp_target;

  function [3:0] cae_kind;
    input [7:0] code;
    begin
      casez (code)
        `CAE_OP_ADD_WITH_CARRY_OP_REG, `CAE_OP_ADD_WITH_CARRY_OP_IND, `CAE_OP_ADD_WITH_CARRY_OP_DIR, `CAE_OP_ADD_WITH_CARRY_OP_IMM: cae_kind = `CAE_K_ADD_WITH_CARRY_OP;
        `CAE_OP_AND_REG, `CAE_OP_AND_IND, `CAE_OP_AND_DIR, `CAE_OP_AND_IMM:     cae_kind = `CAE_K_AND_A;
        `CAE_OP_AND_DA:  cae_kind = `CAE_K_AND_DA;
        `CAE_OP_AND_DI:  cae_kind = `CAE_K_AND_DI;
        `CAE_OP_AND_CB:  cae_kind = `CAE_K_AND_CB;
        `CAE_OP_AND_CNB: cae_kind = `CAE_K_AND_CNB;
        `CAE_OP_CMP_AD:  cae_kind = `CAE_K_CMP_AD;
        `CAE_OP_CMP_AI:  cae_kind = `CAE_K_CMP_AI;
        `CAE_OP_CMP_RI:  cae_kind = `CAE_K_CMP_RI;
        `CAE_OP_CMP_II:  cae_kind = `CAE_K_CMP_II;
        `CAE_OP_JUMP_PAGE: cae_kind = `CAE_K_JUMP;
        default:         cae_kind = `CAE_K_NONE;
      endcase
    end
  endfunction

  function [2:0] cae_src;
    input [3:0] k;
    input [7:0] code;
    begin
      case (k)
        `CAE_K_ADD_WITH_CARRY_OP, `CAE_K_AND_A: begin
          if (code[3])
            cae_src = `CAE_SRC_REG;
          else if (code[2:1] == 2'b11)
            cae_src = `CAE_SRC_IND;
          else if (code[0])
            cae_src = `CAE_SRC_DIR;
          else
            cae_src = `CAE_SRC_NONE;
        end
        `CAE_K_AND_DA, `CAE_K_AND_DI, `CAE_K_CMP_AD: cae_src = `CAE_SRC_DIR;
        `CAE_K_AND_CB, `CAE_K_AND_CNB:               cae_src = `CAE_SRC_BIT;
        `CAE_K_CMP_RI:                               cae_src = `CAE_SRC_REG;
        `CAE_K_CMP_II:                               cae_src = `CAE_SRC_IND;
        default:                                     cae_src = `CAE_SRC_NONE;
      endcase
    end
  endfunction

  function [1:0] cae_mcs;
    input [3:0] k;
    begin
      case (k)
        `CAE_K_JUMP, `CAE_K_AND_DI, `CAE_K_AND_CB, `CAE_K_AND_CNB,
        `CAE_K_CMP_AD, `CAE_K_CMP_AI, `CAE_K_CMP_RI, `CAE_K_CMP_II: cae_mcs = `CAE_MC_TWO;
        default: cae_mcs = `CAE_MC_ONE;
      endcase
    end
  endfunction

  assign busy_o     = (state != S_IDLE);
  assign mc_tick    = (state != S_IDLE) && (div == MC_CLKS - 4'h1);
  assign next_jump  = pc_base + `CAE_LEN_JUMP;
  assign next_cmp   = pc_base + `CAE_LEN_CMP;
  assign cmp_target = next_cmp + {{8{b3[7]}}, b3};

  // Operand routing: compare forms put the fetched byte first unless the accumulator leads
  always @* begin
    alu_a = acc;
    alu_b = opnd;
    case (kind)
      `CAE_K_ADD_WITH_CARRY_OP, `CAE_K_AND_A: begin
        alu_b = (src == `CAE_SRC_NONE) ? b2 : opnd;
      end
      `CAE_K_AND_DA: begin
        alu_a = opnd;
        alu_b = acc;
      end
      `CAE_K_AND_DI: begin
        alu_a = opnd;
        alu_b = b3;
      end
      `CAE_K_CMP_AI: begin
        alu_b = b2;
      end
      `CAE_K_CMP_RI, `CAE_K_CMP_II: begin
        alu_a = opnd;
        alu_b = b2;
      end
      default: begin
        alu_a = acc;
        alu_b = opnd;
      end
    endcase
  end

  cae_alu u_alu (
    .a_i         (alu_a),
    .b_i         (alu_b),
    .cin_i       (cy),
    .sum_o       (sum),
    .carry_o     (add_cy),
    .aux_carry_o (add_ac),
    .overflow_o  (add_ov),
    .and_o       (and_res),
    .less_o      (less),
    .unequal_o   (unequal)
  );

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      state                <= S_IDLE;
      kind                 <= `CAE_K_NONE;
      src                  <= `CAE_SRC_NONE;
      op                   <= 8'h00;
      b2                   <= 8'h00;
      b3                   <= 8'h00;
      pc_base              <= 16'h0000;
      acc                  <= 8'h00;
      cy                   <= 1'b0;
      ptr_pending          <= 1'b0;
      opnd                 <= 8'h00;
      mc_left              <= 2'h0;
      div                  <= 4'h0;
      done_o               <= 1'b0;
      mem_rd_o             <= 1'b0;
      mem_wr_o             <= 1'b0;
      mem_rmw_o            <= 1'b0;
      mem_space_o          <= `CAE_SP_DIR;
      mem_addr_o           <= 8'h00;
      mem_wdata_o          <= 8'h00;
      acc_we_o             <= 1'b0;
      acc_o                <= 8'h00;
      carry_we_o           <= 1'b0;
      carry_o              <= 1'b0;
      aux_carry_we_o       <= 1'b0;
      aux_carry_flag_o     <= 1'b0;
      overflow_we_o        <= 1'b0;
      overflow_flag_o      <= 1'b0;
      program_counter_we_o <= 1'b0;
      program_counter_o    <= 16'h0000;
    end else begin
      done_o               <= 1'b0;
      mem_rd_o             <= 1'b0;
      mem_wr_o             <= 1'b0;
      acc_we_o             <= 1'b0;
      carry_we_o           <= 1'b0;
      aux_carry_we_o       <= 1'b0;
      overflow_we_o        <= 1'b0;
      program_counter_we_o <= 1'b0;
      // Machine-cycle divider restarts with each instruction so its length is exact
      if (state == S_IDLE || mc_tick)
        div <= 4'h0;
      else
        div <= div + 4'h1;
      if (mc_tick && mc_left != 2'h0)
        mc_left <= mc_left - 2'h1;
      case (state)
        S_IDLE: begin
          if (start_i) begin
            kind        <= cae_kind(opcode_i);
            src         <= cae_src(cae_kind(opcode_i), opcode_i);
            mc_left     <= cae_mcs(cae_kind(opcode_i));
            op          <= opcode_i;
            b2          <= byte2_i;
            b3          <= byte3_i;
            pc_base     <= program_counter_i;
            acc         <= acc_i;
            cy          <= carry_i;
            ptr_pending <= 1'b0;
            mem_rmw_o   <= 1'b0;
            mem_space_o <= `CAE_SP_DIR;
            state       <= S_READ;
            case (cae_src(cae_kind(opcode_i), opcode_i))
              `CAE_SRC_REG: begin
                mem_rd_o   <= 1'b1;
                mem_addr_o <= {3'b000, bank_i, opcode_i[2:0]};
              end
              `CAE_SRC_IND: begin
                // Pointer register first; its value addresses the second read
                mem_rd_o    <= 1'b1;
                mem_addr_o  <= {3'b000, bank_i, 2'b00, opcode_i[0]};
                ptr_pending <= 1'b1;
              end
              `CAE_SRC_DIR: begin
                mem_rd_o   <= 1'b1;
                mem_addr_o <= byte2_i;
                mem_rmw_o  <= (cae_kind(opcode_i) == `CAE_K_AND_DA) ||
                              (cae_kind(opcode_i) == `CAE_K_AND_DI);
              end
              `CAE_SRC_BIT: begin
                mem_rd_o    <= 1'b1;
                mem_addr_o  <= byte2_i;
                mem_space_o <= `CAE_SP_BIT;
              end
              default: begin
                state <= S_EXEC;
              end
            endcase
          end
        end
        S_READ: begin
          if (ptr_pending) begin
            ptr_pending <= 1'b0;
            mem_rd_o    <= 1'b1;
            mem_space_o <= `CAE_SP_IND;
            mem_addr_o  <= mem_rdata_i;
          end else begin
            opnd  <= mem_rdata_i;
            state <= S_EXEC;
          end
        end
        S_EXEC: begin
          state <= S_WAIT;
          case (kind)
            `CAE_K_ADD_WITH_CARRY_OP: begin
              acc_we_o         <= 1'b1;
              acc_o            <= sum;
              carry_we_o       <= 1'b1;
              carry_o          <= add_cy;
              aux_carry_we_o   <= 1'b1;
              aux_carry_flag_o <= add_ac;
              overflow_we_o    <= 1'b1;
              overflow_flag_o  <= add_ov;
            end
            `CAE_K_JUMP: begin
              program_counter_we_o <= 1'b1;
              program_counter_o    <= {next_jump[15:11], op[7:5], b2};
            end
            `CAE_K_AND_A: begin
              acc_we_o <= 1'b1;
              acc_o    <= and_res;
            end
            `CAE_K_AND_DA, `CAE_K_AND_DI: begin
              mem_wr_o    <= 1'b1;
              mem_rmw_o   <= 1'b0;
              mem_space_o <= `CAE_SP_DIR;
              mem_addr_o  <= b2;
              mem_wdata_o <= and_res;
            end
            `CAE_K_AND_CB: begin
              carry_we_o <= 1'b1;
              carry_o    <= cy & opnd[0];
            end
            `CAE_K_AND_CNB: begin
              // Inverted copy only; the addressed bit itself is never written back
              carry_we_o <= 1'b1;
              carry_o    <= cy & ~opnd[0];
            end
            `CAE_K_CMP_AD, `CAE_K_CMP_AI, `CAE_K_CMP_RI, `CAE_K_CMP_II: begin
              carry_we_o           <= 1'b1;
              carry_o              <= less;
              program_counter_we_o <= 1'b1;
              program_counter_o    <= unequal ? cmp_target : next_cmp;
            end
            default: begin
              mem_rmw_o <= 1'b0;
            end
          endcase
        end
        S_WAIT: begin
          if (mc_tick && mc_left == 2'h1) begin
            done_o <= 1'b1;
            state  <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // cae_exec

/* File: sim/cae_exec_chk.sv */
// Checker for the executor: timing, flag values, jump targets, memory strobes.
// Assumes binding to cae_exec with the default twelve clocks per machine cycle.
`timescale 1ns/1ps
module cae_exec_chk #(
  parameter [3:0] MC_CLKS = 4'hc
) (
  input wire        ref_clk_i,
  input wire        reset_i,
  input wire        start_i,
  input wire [7:0]  opcode_i,
  input wire [7:0]  byte2_i,
  input wire [7:0]  byte3_i,
  input wire [15:0] program_counter_i,
  input wire [7:0]  acc_i,
  input wire        carry_i,
  input wire        busy_o,
  input wire        done_o,
  input wire        mem_rd_o,
  input wire        mem_wr_o,
  input wire        mem_rmw_o,
  input wire        acc_we_o,
  input wire [7:0]  acc_o,
  input wire        carry_we_o,
  input wire        carry_o,
  input wire        aux_carry_we_o,
  input wire        aux_carry_flag_o,
  input wire        overflow_we_o,
  input wire        overflow_flag_o,
  input wire        program_counter_we_o,
  input wire [15:0] program_counter_o
);
  reg  [7:0]  op_q, b2_q, b3_q, a_q;
  reg         c_q;
  reg  [15:0] pc_q;
  wire        take  = start_i && !busy_o;
  wire        two_c = (opcode_i[4:0] == 5'h01) || (opcode_i == 8'h53) || (opcode_i == 8'h82) ||
                      (opcode_i == 8'hb0) || (opcode_i[7:2] == 6'h2d) || (opcode_i[7:3] == 5'h17);
  wire [8:0]  sum9  = a_q + b2_q + c_q;
  wire        c3    = ({1'b0, a_q[3:0]} + b2_q[3:0] + c_q) > 5'h0f;
  wire        c6    = ({1'b0, a_q[6:0]} + b2_q[6:0] + c_q) > 8'h7f;
  wire [15:0] pc2   = pc_q + 16'h0002;
  wire [15:0] cmp_t = pc_q + 16'h0003 + ((a_q != b2_q) ? {{8{b3_q[7]}}, b3_q} : 16'h0000);

  // Operands are held here because the outputs appear long after the inputs may change
  always @(posedge ref_clk_i) begin
    if (take && !reset_i) begin
      op_q <= opcode_i;
      b2_q <= byte2_i;
      b3_q <= byte3_i;
      a_q  <= acc_i;
      c_q  <= carry_i;
      pc_q <= program_counter_i;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  chk_busy_start: assert property (take |=> busy_o) else $error("busy not raised");
  chk_one_cycle: assert property (take && !two_c |-> ##[12:13] done_o)
    else $error("one-cycle instruction late");
  chk_two_cycle: assert property (take && two_c |=> !done_o [*8] ##[16:17] done_o)
    else $error("two-cycle instruction timing wrong");
  chk_done_pulse: assert property (done_o |=> !done_o) else $error("done longer than one cycle");
  chk_add_with_carry_op_sum: assert property (acc_we_o && op_q == 8'h34 |-> {carry_o, acc_o} == sum9 && aux_carry_flag_o == c3)
    else $error("add-with-carry result wrong");
  chk_add_with_carry_op_ovf: assert property (overflow_we_o && op_q == 8'h34 |-> overflow_flag_o == (c6 ^ sum9[8]))
    else $error("overflow flag wrong");
  chk_and_noflag: assert property (acc_we_o && op_q[7:4] == 4'h5 |-> !carry_we_o && !aux_carry_we_o && !overflow_we_o)
    else $error("byte AND touched a flag");
  chk_rmw_latch: assert property (mem_rd_o && (op_q == 8'h52 || op_q == 8'h53) |-> mem_rmw_o)
    else $error("AND into direct read without latch select");
  chk_page_target: assert property (program_counter_we_o && op_q[4:0] == 5'h01 |->
    program_counter_o == {pc2[15:11], op_q[7:5], b2_q}) else $error("page jump target wrong");
  chk_cmp_target: assert property (program_counter_we_o && op_q == 8'hb4 |-> program_counter_o == cmp_t)
    else $error("compare-branch target wrong");
  chk_cmp_carry: assert property (carry_we_o && op_q == 8'hb4 |-> carry_o == (a_q < b2_q))
    else $error("compare-branch carry wrong");
  chk_bit_nowrite: assert property (mem_wr_o |-> op_q != 8'h82 && op_q != 8'hb0)
    else $error("bit AND wrote memory");
endmodule // cae_exec_chk

bind cae_exec cae_exec_chk #(.MC_CLKS(MC_CLKS)) chk_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
  .start_i(start_i), .opcode_i(opcode_i), .byte2_i(byte2_i), .byte3_i(byte3_i),
  .program_counter_i(program_counter_i), .acc_i(acc_i), .carry_i(carry_i), .busy_o(busy_o),
  .done_o(done_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_rmw_o(mem_rmw_o),
  .acc_we_o(acc_we_o), .acc_o(acc_o), .carry_we_o(carry_we_o), .carry_o(carry_o),
  .aux_carry_we_o(aux_carry_we_o), .aux_carry_flag_o(aux_carry_flag_o), .overflow_we_o(overflow_we_o),
  .overflow_flag_o(overflow_flag_o), .program_counter_we_o(program_counter_we_o),
  .program_counter_o(program_counter_o));

/* File: sim/cae_exec_tb_top.sv */
// Self-checking bench for the executor, with a one-cycle memory model.
// Assumes the checker is bound by its own file; MC_CLKS kept at twelve.
`timescale 1ns/1ps
module cae_exec_tb_top;
  reg         ref_clk_i = 1'b0;
  reg         reset_i = 1'b1;
  reg         start_i = 1'b0;
  reg  [7:0]  opcode_i = 8'h00, byte2_i = 8'h00, byte3_i = 8'h00, acc_i = 8'h00, mem_rdata_i = 8'h00;
  reg  [15:0] program_counter_i = 16'h0000;
  reg  [1:0]  bank_i = 2'h0;
  reg         carry_i = 1'b0;
  wire        busy_o, done_o, mem_rd_o, mem_wr_o, mem_rmw_o, acc_we_o, carry_we_o, carry_o;
  wire        aux_carry_we_o, aux_carry_flag_o, overflow_we_o, overflow_flag_o, program_counter_we_o;
  wire [1:0]  mem_space_o;
  wire [7:0]  mem_addr_o, mem_wdata_o, acc_o;
  wire [15:0] program_counter_o;
  reg  [7:0]  dir [0:255];
  reg  [7:0]  ind [0:255];
  reg  [31:0] seed = 32'd31;
  reg  [31:0] r1;
  integer     err_count = 0;
  integer     checked = 0;
  integer     i, n, e_n;
  reg         e_aw, e_cw, e_fw, e_pw, e_wr, e_c, e_ac, e_ov, g_aw, g_cw, g_fw, g_pw, g_wr, g_c, g_ac, g_ov;
  reg  [7:0]  e_acc, e_wa, e_wd, g_acc, g_wa, g_wd, op;
  reg  [15:0] e_pc, g_pc;

  always #25 ref_clk_i = ~ref_clk_i;

  cae_exec #(.MC_CLKS(4'hc)) dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .start_i(start_i),
    .opcode_i(opcode_i), .byte2_i(byte2_i), .byte3_i(byte3_i), .program_counter_i(program_counter_i),
    .bank_i(bank_i), .acc_i(acc_i), .carry_i(carry_i), .mem_rdata_i(mem_rdata_i), .busy_o(busy_o),
    .done_o(done_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_rmw_o(mem_rmw_o),
    .mem_space_o(mem_space_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .acc_we_o(acc_we_o),
    .acc_o(acc_o), .carry_we_o(carry_we_o), .carry_o(carry_o), .aux_carry_we_o(aux_carry_we_o),
    .aux_carry_flag_o(aux_carry_flag_o), .overflow_we_o(overflow_we_o), .overflow_flag_o(overflow_flag_o),
    .program_counter_we_o(program_counter_we_o), .program_counter_o(program_counter_o));

  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction

  function bitv(input [7:0] a);
    bitv = ^a;
  endfunction

  // Memory answers within the strobe's own cycle, because the executor takes read data on the
  // edge that closes that cycle; idle data toggles so a stale value cannot pass
  always @(posedge ref_clk_i) begin
    if (mem_wr_o) begin
      dir[mem_addr_o] = mem_wdata_o;
      {g_wr, g_wa, g_wd} = {1'b1, mem_addr_o, mem_wdata_o};
    end
    if (acc_we_o) {g_aw, g_acc} = {1'b1, acc_o};
    if (carry_we_o) {g_cw, g_c} = {1'b1, carry_o};
    if (aux_carry_we_o) {g_fw, g_ac, g_ov} = {1'b1, aux_carry_flag_o, overflow_flag_o};
    if (program_counter_we_o) {g_pw, g_pc} = {1'b1, program_counter_o};
    #1;
    if (mem_rd_o) mem_rdata_i = (mem_space_o == 2'h1) ? ind[mem_addr_o] :
                                (mem_space_o == 2'h2) ? {mem_addr_o[7:1], bitv(mem_addr_o)} : dir[mem_addr_o];
    else mem_rdata_i = ~mem_rdata_i;
  end

  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task final_report;
    begin
      if (err_count == 0 && checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task model;
    reg [7:0] x, f, s2;
    reg [8:0] t;
    reg [15:0] t2;
    begin
      {e_aw, e_cw, e_fw, e_pw, e_wr} = 5'h00;
      e_n = 12;
      x = op[3] ? dir[{3'h0, bank_i, op[2:0]}] : (op[3:1] == 3'h3) ? ind[dir[{3'h0, bank_i, 2'h0, op[0]}]] :
          (op[3:0] == 4'h5) ? dir[byte2_i] : byte2_i;
      if (op[7:4] == 4'h3 && op[3:2] != 2'h0) begin
        t = acc_i + x + carry_i;
        {e_c, e_acc} = t;
        e_ac = ({1'b0, acc_i[3:0]} + x[3:0] + carry_i) > 5'h0f;
        e_ov = (({1'b0, acc_i[6:0]} + x[6:0] + carry_i) > 8'h7f) ^ t[8];
        {e_aw, e_cw, e_fw} = 3'h7;
      end else if (op[7:4] == 4'h5 && op[3:2] != 2'h0) begin
        {e_aw, e_acc} = {1'b1, acc_i & x};
      end else if (op == 8'h52 || op == 8'h53) begin
        {e_wr, e_wa, e_wd} = {1'b1, byte2_i, dir[byte2_i] & (op[0] ? byte3_i : acc_i)};
        e_n = op[0] ? 24 : 12;
      end else if (op == 8'h82 || op == 8'hb0) begin
        {e_cw, e_c} = {1'b1, carry_i & (bitv(byte2_i) ^ op[5])};
        e_n = 24;
      end else if (op[7:4] == 4'hb && op[3:2] != 2'h0) begin
        f = (op[3:1] == 3'h2) ? acc_i : x;
        s2 = (op[3:1] == 3'h2) ? x : byte2_i;
        {e_cw, e_c, e_pw} = {1'b1, f < s2, 1'b1};
        e_pc = program_counter_i + 16'h0003 + ((f != s2) ? {{8{byte3_i[7]}}, byte3_i} : 16'h0000);
        e_n = 24;
      end else if (op[4:0] == 5'h01) begin
        t2 = program_counter_i + 16'h0002;
        {e_pw, e_pc} = {1'b1, t2[15:11], op[7:5], byte2_i};
        e_n = 24;
      end
    end
  endtask

  // Next start is presented in the done cycle, so every instruction runs back to back
  task go(input [7:0] o, input [7:0] b2, input [7:0] b3, input [15:0] pc, input [7:0] a, input c);
    begin
      {opcode_i, byte2_i, byte3_i, program_counter_i, acc_i, carry_i} = {o, b2, b3, pc, a, c};
      op = o;
      {g_aw, g_cw, g_fw, g_pw, g_wr} = 5'h00;
      model;
      start_i = 1'b1;
      @(posedge ref_clk_i);
      #1 start_i = 1'b0;
      n = 0;
      while (done_o !== 1'b1) begin
        @(posedge ref_clk_i);
        #1 n = n + 1;
        if (n > 40) begin
          err_count = err_count + 1;
          final_report;
        end
      end
      chk(n, e_n);
      chk({g_aw, g_cw, g_fw, g_pw, g_wr}, {e_aw, e_cw, e_fw, e_pw, e_wr});
      if (e_aw) chk(g_acc, e_acc);
      if (e_cw) chk(g_c, e_c);
      if (e_fw) chk({g_ac, g_ov}, {e_ac, e_ov});
      if (e_pw) chk(g_pc, e_pc);
      if (e_wr) chk({g_wa, g_wd}, {e_wa, e_wd});
    end
  endtask

  initial begin
    for (i = 0; i < 256; i = i + 1) begin
      seed = xs(seed);
      {ind[i], dir[i]} = seed[15:0];
    end
    repeat (2) @(posedge ref_clk_i);
    #1 reset_i = 1'b0;
    @(posedge ref_clk_i);
    #1 chk({busy_o, done_o, acc_we_o, program_counter_we_o}, 4'h0);
    go(8'h34, 8'h00, 8'h00, 16'h0100, 8'hff, 1'b1);
    go(8'h34, 8'h00, 8'h00, 16'h0100, 8'h7f, 1'b1);
    go(8'h34, 8'haa, 8'h00, 16'h0100, 8'hc3, 1'b1);
    go(8'hb4, 8'h5a, 8'hf0, 16'h2000, 8'h5a, 1'b1);
    go(8'hb4, 8'h60, 8'h80, 16'h2000, 8'h34, 1'b0);
    go(8'he1, 8'h23, 8'h00, 16'h07fe, 8'h00, 1'b0);
    go(8'ha5, 8'h11, 8'h22, 16'h0300, 8'h44, 1'b1);
    bank_i = 2'h1;
    dir[8'h0b] = 8'h77;
    go(8'hbb, 8'h77, 8'h10, 16'h0400, 8'h00, 1'b1);
    for (i = 0; i < 200; i = i + 1) begin
      seed = xs(seed);
      r1 = seed;
      seed = xs(seed);
      bank_i = r1[12:11];
      case (r1[7:0] % 18)
        0: op = {5'h07, r1[10:8]};
        1: op = {7'h1b, r1[8]};
        2: op = 8'h35;
        3: op = 8'h34;
        4: op = {r1[10:8], 5'h01};
        5: op = {5'h0b, r1[10:8]};
        6: op = {7'h2b, r1[8]};
        7: op = 8'h55;
        8: op = 8'h54;
        9: op = 8'h52;
        10: op = 8'h53;
        11: op = 8'h82;
        12: op = 8'hb0;
        13: op = 8'hb5;
        14: op = 8'hb4;
        15: op = {5'h17, r1[10:8]};
        16: op = {7'h5b, r1[8]};
        default: op = 8'ha5;
      endcase
      go(op, seed[7:0], seed[15:8], seed[31:16], r1[23:16], r1[13]);
    end
    final_report;
  end
endmodule // cae_exec_tb_top
